// file: common/iftr_pkg.sv
// Purpose: Shared constants for the instruction fetch address trap
// Assumes: APB register access, 250 MHz pclk
// Notes: Address ranges are parameters of the top module
package iftr_pkg;
   // Register byte offsets
   localparam logic [11:0] GUARD_FIRST_OFS = 12'h034;
   localparam logic [11:0] GUARD_CODE_OFS = 12'h038;
   localparam logic [11:0] TRAP_STATUS_OFS = 12'h03C;
   localparam logic [11:0] TRAP_MASK_OFS = 12'h040;
   localparam logic [11:0] TRAP_CTRL_OFS = 12'h044;
   // Field positions in the first control register
   localparam int RAM_SEL_BIT = 5;
   localparam int ACTION_BIT = 4;
   // Reset values
   localparam logic RAM_SEL_RST = 1'b1;
   localparam logic ACTION_RST = 1'b1;
   localparam logic [1:0] MASK_RST = 2'h0;
   // Code that commits the pending RAM trap select
   localparam logic [7:0] COMMIT_CODE = 8'hD2;
   // Status bit positions
   localparam int ST_IRQ_BIT = 0;
   localparam int ST_RST_BIT = 1;
   // Reset period: at most 24 high-frequency periods
   localparam int HF_RATE_KHZ = 16000;
   localparam int PCLK_RATE_KHZ = 250000;
   localparam int RESET_HF_PERIODS = 24;
   localparam int RESET_CYCLES =
      (RESET_HF_PERIODS * PCLK_RATE_KHZ) / HF_RATE_KHZ;
   localparam int RESET_CNT_W = 9;
   typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_HOLD} iftr_rst_state_t;
endpackage

// file: rtl/iftr_range_det.sv
// Purpose: Classifies one fetch address against RAM and SFR ranges
// Assumes: Ranges are inclusive
// Notes: Purely combinational, registered by the caller
`timescale 1ns/10ps
module iftr_range_det #(
   parameter int AW = 16,
   parameter logic [AW-1:0] RAM_LO = '0,
   parameter logic [AW-1:0] RAM_HI = '0,
   parameter logic [AW-1:0] SFR_LO = '0,
   parameter logic [AW-1:0] SFR_HI = '0
)
(
   input wire logic [AW-1:0] addr,
   output logic in_ram,
   output logic in_sfr
);
   assign in_ram = (addr >= RAM_LO) && (addr <= RAM_HI);
   assign in_sfr = (addr >= SFR_LO) && (addr <= SFR_HI);
endmodule // iftr_range_det

// file: rtl/iftr_trap.sv
// Purpose: Instruction fetch address trap with APB control registers
// Assumes: Fetch strobe is one cycle per fetch, synchronous to pclk
// Notes: Shares register offsets with the watchdog control pair
//
// Notes on behaviour
// - Trap bits sit at the same two offsets as the guard registers.
// - RAM trap select decides if RAM fetches trap; clear before RAM code.
// - New RAM select acts only after commit code D2H is written.
// - Fetch from the SFR area traps unless a trap reset sequence is running.
// - Action select chooses interrupt or reset request.
// - Action 0: illegal fetch raises the trap interrupt request.
// - Trap interrupt is non-maskable, ignores master enable flag.
// - Trap preempts any interrupt in service; earlier one stays pending.
// - Action 1: illegal fetch raises a reset request instead.
// - Reset request drives reset pin low, at most 24 fast periods.
// - In low-frequency mode, restart fast oscillator, same reset bound.
// - First control register is write-only; reads give no data.
`timescale 1ns/10ps
module iftr_trap
   import iftr_pkg::*;
#(
   parameter int AW = 16,
   parameter logic [15:0] RAM_LO = 16'h0040,
   parameter logic [15:0] RAM_HI = 16'h023F,
   parameter logic [15:0] SFR_LO = 16'h0000,
   parameter logic [15:0] SFR_HI = 16'h003F
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fetch_valid,
   input wire logic [AW-1:0] fetch_addr,
   input wire logic low_frequency_run_mode,
   input wire logic hf_osc_ready,
   output logic trap_interrupt_request,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic internal_reset_req,
   output logic hf_osc_restart,
   output logic irq
);
   // Fetch decode is written for a 16-bit address only
   if (AW != 16)
   begin : g_aw_check
      $error("iftr_trap supports a 16-bit fetch address only");
   end
   // Reset span must fit the counter; entry edge needs two or more
   if (RESET_CYCLES < 2 || RESET_CYCLES > 2 ** RESET_CNT_W)
   begin : g_span_check
      $error("iftr_trap reset span does not fit its counter");
   end
   localparam int RST_SPAN = RESET_CYCLES;
   localparam logic [RESET_CNT_W:0] RUN_MAX =
      (RESET_CNT_W + 1)'(RESET_CYCLES);

   logic wr_en;
   logic ram_sel_pend_q;
   logic ram_sel_q;
   logic action_q;
   logic [1:0] status_q;
   logic [1:0] mask_q;
   logic in_ram;
   logic in_sfr;
   logic trap_hit;
   logic irq_ev;
   logic rst_ev;
   logic [RESET_CNT_W-1:0] cnt_q;
   iftr_rst_state_t st_q;
   logic [RESET_CNT_W:0] run_q;

   function automatic logic hit_ofs(input logic [11:0] a,
                                    input logic [11:0] o);
      hit_ofs = (a == o);
   endfunction

   assign wr_en = psel && penable && pwrite;

   iftr_range_det #(
      .AW(AW),
      .RAM_LO(RAM_LO),
      .RAM_HI(RAM_HI),
      .SFR_LO(SFR_LO),
      .SFR_HI(SFR_HI)
   ) u_det (
      .addr(fetch_addr),
      .in_ram(in_ram),
      .in_sfr(in_sfr)
   );

   // Trap only while not already resetting; one request per fetch strobe
   assign trap_hit = fetch_valid && (st_q == ST_IDLE) &&
      (in_sfr || (in_ram && ram_sel_q));
   assign irq_ev = trap_hit && !action_q;
   assign rst_ev = trap_hit && action_q;

   // First control register, write-only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ram_sel_pend_q <= RAM_SEL_RST;
         action_q <= ACTION_RST;
      end
      else if (wr_en && hit_ofs(paddr, GUARD_FIRST_OFS))
      begin
         ram_sel_pend_q <= pwdata[RAM_SEL_BIT];
         action_q <= pwdata[ACTION_BIT];
      end
   end

   // Active select moves only on the commit code
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ram_sel_q <= RAM_SEL_RST;
      else if (wr_en && hit_ofs(paddr, GUARD_CODE_OFS) &&
               pwdata[7:0] == COMMIT_CODE)
         ram_sel_q <= ram_sel_pend_q;
   end

   // Non-maskable request: no enable input gates it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trap_interrupt_request <= 1'b0;
      else
         trap_interrupt_request <= irq_ev;
   end

   // Sticky status, set wins over write-one-to-clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_q <= 2'h0;
      else
      begin
         if (wr_en && hit_ofs(paddr, TRAP_STATUS_OFS))
            status_q <= status_q & ~pwdata[1:0];
         if (irq_ev)
            status_q[ST_IRQ_BIT] <= 1'b1;
         if (rst_ev)
            status_q[ST_RST_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask_q <= MASK_RST;
      else if (wr_en && hit_ofs(paddr, TRAP_MASK_OFS))
         mask_q <= pwdata[1:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(status_q & mask_q);
   end

   // Reset sequencer; count bounded by the fast-clock limit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
      end
      else
      begin
         case (st_q)
            ST_IDLE:
            begin
               if (rst_ev)
               begin
                  st_q <= low_frequency_run_mode ? ST_HOLD : ST_RESET;
                  cnt_q <= '0;
               end
            end
            ST_HOLD:
            begin
               if (hf_osc_ready)
                  st_q <= ST_RESET;
            end
            ST_RESET:
            begin
               // Entry edge is the first reset cycle, so stop one short
               if (cnt_q == RESET_CNT_W'(RESET_CYCLES - 2))
                  st_q <= ST_IDLE;
               else
                  cnt_q <= cnt_q + 1'b1;
            end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reset_pin_out <= 1'b1;
         reset_pin_oe <= 1'b0;
         internal_reset_req <= 1'b0;
         hf_osc_restart <= 1'b0;
      end
      else
      begin
         reset_pin_out <= 1'b0;
         reset_pin_oe <= (st_q != ST_IDLE) || rst_ev;
         internal_reset_req <= (st_q != ST_IDLE) || rst_ev;
         hf_osc_restart <= (st_q == ST_HOLD) ||
            (rst_ev && low_frequency_run_mode);
      end
   end

   // APB read side; first control register reads zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         case (paddr)
            TRAP_STATUS_OFS: prdata <= {30'h0, status_q};
            TRAP_MASK_OFS: prdata <= {30'h0, mask_q};
            TRAP_CTRL_OFS:
               prdata <= {29'h0, action_q, ram_sel_q, ram_sel_pend_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Zero wait states, still driven from a flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pready <= 1'b1;
      else
         pready <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pslverr <= 1'b0;
      else
         pslverr <= psel && !penable &&
            !(hit_ofs(paddr, GUARD_FIRST_OFS) ||
            hit_ofs(paddr, GUARD_CODE_OFS) ||
            hit_ofs(paddr, TRAP_STATUS_OFS) ||
            hit_ofs(paddr, TRAP_MASK_OFS) || hit_ofs(paddr, TRAP_CTRL_OFS));
   end

   property p_sfr_irq;
      @(posedge pclk) disable iff (!presetn)
      fetch_valid && in_sfr && !action_q && st_q == ST_IDLE
         |=> trap_interrupt_request;
   endproperty
   a_sfr_irq: assert property (p_sfr_irq) else $error("sfr no irq");

   property p_ram_off;
      @(posedge pclk) disable iff (!presetn)
      fetch_valid && in_ram && !in_sfr && !ram_sel_q
         |=> !trap_interrupt_request;
   endproperty
   a_ram_off: assert property (p_ram_off) else $error("ram irq");

   property p_commit;
      @(posedge pclk) disable iff (!presetn)
      !(wr_en && paddr == GUARD_CODE_OFS && pwdata[7:0] == COMMIT_CODE)
         |=> $stable(ram_sel_q);
   endproperty
   a_commit: assert property (p_commit) else $error("sel moved");

   property p_rst_act;
      @(posedge pclk) disable iff (!presetn)
      rst_ev |=> internal_reset_req && reset_pin_oe && !trap_interrupt_request;
   endproperty
   a_rst_act: assert property (p_rst_act) else $error("no reset");

   property p_rst_len;
      @(posedge pclk) disable iff (!presetn)
      rst_ev && !low_frequency_run_mode |=> ##[1:RST_SPAN] !internal_reset_req;
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("rst span");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      rst_ev && low_frequency_run_mode |=> hf_osc_restart;
   endproperty
   a_hold: assert property (p_hold) else $error("no restart");

   property p_one;
      @(posedge pclk) disable iff (!presetn)
      trap_interrupt_request |-> $past(fetch_valid);
   endproperty
   a_one: assert property (p_one) else $error("spurious");

   property p_irq_out;
      @(posedge pclk) disable iff (!presetn)
      irq_ev && mask_q[ST_IRQ_BIT] |=> ##1 irq;
   endproperty
   a_irq_out: assert property (p_irq_out) else $error("irq lost");

   // Checker helper: reset cycles after any oscillator wait
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_q <= '0;
      else if (!internal_reset_req || hf_osc_restart)
         run_q <= '0;
      else if (run_q != '1)
         run_q <= run_q + 1'b1;
   end

   property p_rst_max;
      @(posedge pclk) disable iff (!presetn)
      run_q <= RUN_MAX;
   endproperty
   a_rst_max: assert property (p_rst_max) else $error("rst long");

   property p_excl;
      @(posedge pclk) disable iff (!presetn)
      !(trap_interrupt_request && internal_reset_req);
   endproperty
   a_excl: assert property (p_excl) else $error("both req");

   property p_first_wo;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == GUARD_FIRST_OFS
         |=> prdata == 32'h0000_0000;
   endproperty
   a_first_wo: assert property (p_first_wo) else $error("wo read");

   property p_set_wins;
      @(posedge pclk) disable iff (!presetn)
      irq_ev |=> status_q[ST_IRQ_BIT];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set lost");

   c_irq: cover property (@(posedge pclk) irq_ev);
   c_hold: cover property (@(posedge pclk) st_q == ST_HOLD);
   c_sfr: cover property (@(posedge pclk) trap_hit && in_sfr);
   c_rst: cover property (@(posedge pclk) rst_ev);
   c_commit: cover property (@(posedge pclk) $changed(ram_sel_q));
endmodule // iftr_trap

// file: sim/iftr_core_model.sv
// Purpose: Core fetch side model for the address trap
// Assumes: One fetch per call, taken at the following edge
// Notes: Idle address bus shows the inverse, never the last value
`timescale 1ns/10ps
module iftr_core_model (
   input wire logic pclk,
   output logic fetch_valid,
   output logic [15:0] fetch_addr,
   input wire logic trap_interrupt_request
);
   int taken = 0;
   initial
   begin
      fetch_valid = 1'b0;
      fetch_addr = 16'hFFFF;
   end
   // Entry taken even with master enable clear; nests at once
   // Stack set before first trap; bench never loops traps unbounded
   always @(posedge pclk)
      if (trap_interrupt_request === 1'b1)
         taken <= taken + 1;
   task automatic fetch(input logic [15:0] a);
      @(posedge pclk);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      @(posedge pclk);
      fetch_valid <= 1'b0;
      fetch_addr <= ~a;
   endtask
endmodule // iftr_core_model

// file: sim/tb.sv
// Purpose: Self-checking bench for the fetch address trap
// Assumes: Default address ranges, 16 MHz fast clock
// Notes: Reset sequence run at full length, short enough here
`timescale 1ns/10ps
module tb;
   import iftr_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic fv, lfm, hfr, tir, rpo, rpoe, irr, hfrs, irq;
   logic [15:0] fa;
   int bad_count = 0;
   int checked = 0;
   int c;
   int nexp = 0;
   typedef struct {logic sel; logic [15:0] a; logic exp;} iftr_row_t;
   iftr_row_t rows [8] = '{
      '{1'b0, 16'h0000, 1'b1}, '{1'b0, 16'h003F, 1'b1},
      '{1'b0, 16'h0040, 1'b0}, '{1'b0, 16'h023F, 1'b0},
      '{1'b1, 16'h0040, 1'b1}, '{1'b1, 16'h023F, 1'b1},
      '{1'b1, 16'h0240, 1'b0}, '{1'b1, 16'h0020, 1'b1}};
   iftr_trap dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .fetch_valid(fv), .fetch_addr(fa),
      .low_frequency_run_mode(lfm), .hf_osc_ready(hfr),
      .trap_interrupt_request(tir), .reset_pin_out(rpo),
      .reset_pin_oe(rpoe), .internal_reset_req(irr),
      .hf_osc_restart(hfrs), .irq(irq));
   iftr_core_model core (.pclk(pclk), .fetch_valid(fv),
      .fetch_addr(fa), .trap_interrupt_request(tir));
   task automatic test_done;
      if (bad_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1); // Watchdog ends a hung wait
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Counts settled reset cycles after any oscillator wait, bounded
   task automatic rst_len;
      c = 0;
      while (irr === 1'b1 && c < 2000)
      begin
         @(posedge pclk);
         #1;
         c++;
      end
      chk("rst len", c, RESET_CYCLES);
   endtask
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial
   begin
      #200000;
      bad_count++;
      test_done;
   end
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      lfm = 1'b0;
      hfr = 1'b1;
      #10;
      chk("in reset", {rpo, rpoe, irr, tir, irq}, 32'h10);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, TRAP_CTRL_OFS, 32'h0);
      chk("ctrl rst", rd[2:0], 32'h7);
      chk("ctrl err", err, 32'h0);
      chk("pready", pready, 32'h1);
      apb(1'b0, GUARD_FIRST_OFS, 32'h0);
      chk("first wo", rd, 32'h0);
      apb(1'b1, GUARD_FIRST_OFS, 32'h0);
      apb(1'b1, GUARD_CODE_OFS, 32'h4E);
      apb(1'b0, TRAP_CTRL_OFS, 32'h0);
      chk("no commit", rd[2:0], 32'h2);
      foreach (rows[i])
      begin
         apb(1'b1, GUARD_FIRST_OFS, {26'h0, rows[i].sel, 5'h0});
         apb(1'b1, GUARD_CODE_OFS, 32'hD2);
         core.fetch(rows[i].a);
         #1;
         chk("trap", tir, rows[i].exp);
         if (rows[i].exp)
            nexp++;
         @(posedge pclk);
         #1;
         chk("one pulse", tir, 32'h0);
      end
      chk("nmi taken", core.taken, nexp);
      chk("masked", irq, 32'h0);
      apb(1'b1, TRAP_MASK_OFS, 32'h1);
      @(posedge pclk);
      #1;
      chk("irq on", irq, 32'h1);
      apb(1'b1, TRAP_STATUS_OFS, 32'h1);
      @(posedge pclk);
      #1;
      chk("irq clr", irq, 32'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped err", err, 32'h1);
      chk("unmapped rd", rd, 32'h0);
      // Action to reset; registers survive a trap reset
      apb(1'b1, GUARD_FIRST_OFS, 32'h30);
      core.fetch(16'h0010);
      #1;
      chk("rst req", {irr, rpoe, tir, rpo}, 32'hC);
      rst_len;
      apb(1'b0, TRAP_STATUS_OFS, 32'h0);
      chk("rst stat", rd[ST_RST_BIT], 32'h1);
      @(posedge pclk);
      lfm <= 1'b1;
      hfr <= 1'b0;
      core.fetch(16'h0100);
      repeat (20) @(posedge pclk);
      #1;
      chk("osc wait", {hfrs, irr}, 32'h3);
      @(posedge pclk);
      hfr <= 1'b1;
      @(posedge pclk);
      rst_len;
      chk("rst done", {hfrs, irr, rpoe}, 32'h0);
      // Second system reset in mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      #1;
      chk("mid reset", {rpo, rpoe, irr, hfrs, tir, irq}, 32'h20);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, TRAP_CTRL_OFS, 32'h0);
      chk("ctrl again", rd[2:0], 32'h7);
      apb(1'b0, TRAP_STATUS_OFS, 32'h0);
      chk("stat again", rd, 32'h0);
      test_done;
   end
endmodule // tb
